/* rtl/ibte_pkg.sv */
// Constants and types for the I2C boot timing and error block
package ibte_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int IDLE_US = 50;
  localparam int IDLE_CYC = (IDLE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PER_RESET_NS = 10000;
  localparam logic [15:0] PER_RESET_CYC = 16'(PER_RESET_NS / CLK_NS);
  // ----------------------------------------------------------------
  // Serial clock budgets per boot phase
  // ----------------------------------------------------------------
  localparam int RESET_PERIODS = 9;
  localparam int START_BITS = 1;
  localparam int BYTE_BITS = 9;
  localparam int DATA_BYTES = 8;
  localparam int START_HALF_EXTRA = 1;
  localparam int ENTRY_PAGE = BYTE_BITS * DATA_BYTES;
  localparam int ENTRY_1B = START_BITS + BYTE_BITS + BYTE_BITS
    + START_BITS + BYTE_BITS + ENTRY_PAGE + START_HALF_EXTRA;
  localparam int ENTRY_2B = ENTRY_1B + BYTE_BITS;
  localparam int HEAD_1B = ENTRY_1B - ENTRY_PAGE;
  localparam int HEAD_2B = ENTRY_2B - ENTRY_PAGE;
  localparam int STOP_PERIODS = 1;
  // ----------------------------------------------------------------
  // Access phase codes and slave data
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_IDLE = 2'h0;
  localparam logic [1:0] PH_DEV = 2'h1;
  localparam logic [1:0] PH_PER = 2'h2;
  localparam logic [1:0] PH_DATA = 2'h3;
  localparam logic [7:0] RESERVED_DATA = 8'h00;
  localparam logic [7:0] SLAVE_LIMIT = 8'h40;

  typedef enum logic [2:0] {
    B_IDLE, B_DETECT, B_RESET, B_HEAD, B_LOAD, B_STOP, B_DONE
  } ibte_boot_state_type;

  typedef enum logic [2:0] {
    M_IDLE, M_DEV, M_PER, M_DATA, M_STOP, M_HUNG
  } ibte_mst_state_type;

  typedef struct packed {
    logic master_arb_timeout_flag;
    logic master_collision_flag;
    logic master_not_acked_flag;
    logic master_timeout_flag;
    logic master_clock_low_timeout_cause;
    logic master_byte_timeout_cause;
    logic master_transaction_timeout_cause;
    logic slave_access_success_flag;
  } ibte_flags_type;
endpackage : ibte_pkg

/* rtl/ibte_core.sv */
// Boot load sequencer, master error handling and slave reserved access
`timescale 1ns/1ps
// Functional notes
// R1 - Wait 50 us bus idle before boot
// R2 - Nine clock periods of EEPROM reset
// R3 - 102 periods per entry, plus header entry
// R4 - Boot ends with one-period STOP
// R5 - Serial clock period resets to 10 us
// R6 - Two-byte addressing costs 111 periods
// R7 - Entry cost built from its bit fields
// R8 - Unlimited page mode costs 72 per entry
// R9 - Chain reloads serial clock period
// R10 - Arbitration loss in addressing sets arb-timeout
// R11 - Later arbitration loss sets collision flag
// R12 - NACK aborts, STOP, records phase, flags
// R13 - Byte/transaction timeout aborts, STOP, sub-cause
// R14 - Clock-low timeout aborts; bus hung
// R15 - Reserved slave read acked, returns zero
// R16 - Reserved slave write acked, discarded
// R17 - Burst into reserved space behaves likewise
// R18 - Enabled sticky flag drives interrupt
module ibte_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  output logic scl_pin_out,
  output logic scl_pin_oe,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic boot_start,
  input wire logic [15:0] boot_register_count,
  input wire logic two_byte_addr,
  input wire logic page_unlimited,
  input wire logic chain_req,
  input wire logic [15:0] chain_register_count,
  input wire logic [15:0] serial_clock_period,
  output logic boot_busy,
  output logic boot_done,
  input wire logic master_transfer_control,
  input wire logic mst_is_write,
  input wire logic mst_byte_done,
  input wire logic mst_done,
  input wire logic ev_arb_lost,
  input wire logic ev_arb_expired,
  input wire logic ev_nack,
  input wire logic ev_byte_timeout,
  input wire logic ev_trans_timeout,
  input wire logic ev_scl_low_timeout,
  input wire logic stop_legal,
  input wire logic bus_recover,
  output logic mst_abort,
  output logic mst_stop_req,
  output logic mst_hung,
  output logic [1:0] access_progress_status,
  input wire logic slv_addr_valid,
  input wire logic [7:0] slv_addr,
  input wire logic slv_rd_req,
  input wire logic slv_wr_req,
  input wire logic [7:0] slv_wdata,
  input wire logic slv_done,
  input wire logic [7:0] reg_rdata,
  output logic slv_addr_ack,
  output logic [7:0] slv_rdata,
  output logic reg_we,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire ibte_pkg::ibte_flags_type flag_enable,
  input wire ibte_pkg::ibte_flags_type flag_clear,
  output ibte_pkg::ibte_flags_type flag_status,
  output logic irq
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic bus_idle;
  always_ff @(posedge clk) begin
    scl_sync <= {scl_sync[0], scl_pin_in};
    sda_sync <= {sda_sync[0], sda_pin_in};
  end
  assign bus_idle = scl_sync[1] & sda_sync[1];

  // ----------------------------------------------------------------
  // Boot load sequencer
  // ----------------------------------------------------------------
  ibte_pkg::ibte_boot_state_type bst, next_bst;
  logic [15:0] per, next_per;
  logic [15:0] cnt, next_cnt;
  logic [7:0] pcnt, next_pcnt;
  logic [16:0] rem, next_rem;
  logic chain_pend, next_chain_pend;
  logic tick;
  logic [7:0] budget;

  assign tick = (cnt == per - 16'h0001);

  always_comb begin
    if (bst == ibte_pkg::B_RESET) begin
      budget = 8'(ibte_pkg::RESET_PERIODS); // see R2
    end else if (bst == ibte_pkg::B_STOP) begin
      budget = 8'(ibte_pkg::STOP_PERIODS); // see R4
    end else if (bst == ibte_pkg::B_HEAD) begin
      budget = two_byte_addr ? 8'(ibte_pkg::HEAD_2B)
        : 8'(ibte_pkg::HEAD_1B); // see R8
    end else if (page_unlimited) begin
      budget = 8'(ibte_pkg::ENTRY_PAGE); // see R8
    end else begin
      budget = two_byte_addr ? 8'(ibte_pkg::ENTRY_2B)
        : 8'(ibte_pkg::ENTRY_1B); // see R3, R6, R7
    end
  end

  always_comb begin
    next_bst = bst;
    next_per = per;
    next_cnt = cnt;
    next_pcnt = pcnt;
    next_rem = rem;
    next_chain_pend = chain_pend | chain_req;
    case (bst)
      ibte_pkg::B_IDLE: begin
        next_cnt = 16'h0000;
        if (boot_start) begin
          next_bst = ibte_pkg::B_DETECT;
        end
      end
      ibte_pkg::B_DETECT: begin
        // Any bus activity restarts the idle window
        if (!bus_idle) begin
          next_cnt = 16'h0000;
        end else if (cnt == 16'(ibte_pkg::IDLE_CYC - 1)) begin
          next_cnt = 16'h0000;
          next_pcnt = 8'h00;
          next_bst = ibte_pkg::B_RESET; // see R1
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
      ibte_pkg::B_DONE: begin
        next_cnt = 16'h0000;
      end
      default: begin
        next_cnt = tick ? 16'h0000 : cnt + 16'h0001;
        if (tick) begin
          next_pcnt = pcnt + 8'h01;
          if (pcnt == budget - 8'h01) begin
            next_pcnt = 8'h00;
            if (bst == ibte_pkg::B_RESET) begin
              next_rem = {1'b0, boot_register_count} + 17'h00001; // see R3
              next_bst = page_unlimited ? ibte_pkg::B_HEAD : ibte_pkg::B_LOAD;
            end else if (bst == ibte_pkg::B_HEAD) begin
              next_bst = ibte_pkg::B_LOAD;
            end else if (bst == ibte_pkg::B_STOP) begin
              next_bst = ibte_pkg::B_DONE;
            end else if (chain_pend) begin
              // Chain only at an entry boundary, new speed from here
              next_chain_pend = 1'b0;
              next_per = serial_clock_period; // see R9
              next_rem = rem - 17'h00001
                + {1'b0, chain_register_count} + 17'h00001;
              next_bst = page_unlimited ? ibte_pkg::B_HEAD
                : ibte_pkg::B_LOAD; // see R8
            end else if (rem == 17'h00001) begin
              next_bst = ibte_pkg::B_STOP; // see R4
            end else begin
              next_rem = rem - 17'h00001;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bst <= ibte_pkg::B_IDLE;
      per <= ibte_pkg::PER_RESET_CYC; // see R5
      cnt <= 16'h0000;
      pcnt <= 8'h00;
      rem <= 17'h00000;
      chain_pend <= 1'b0;
    end else begin
      bst <= next_bst;
      per <= next_per;
      cnt <= next_cnt;
      pcnt <= next_pcnt;
      rem <= next_rem;
      chain_pend <= next_chain_pend;
    end
  end

  // Open drain: only the low half of each period is driven
  assign boot_busy = (bst != ibte_pkg::B_IDLE) && (bst != ibte_pkg::B_DONE);
  assign boot_done = (bst == ibte_pkg::B_DONE);
  assign scl_pin_out = 1'b0;
  assign scl_pin_oe = boot_busy && (bst != ibte_pkg::B_DETECT)
    && (cnt < {1'b0, per[15:1]});
  assign sda_pin_out = 1'b0;
  assign sda_pin_oe = 1'b0;

  // ----------------------------------------------------------------
  // Master error handling
  // ----------------------------------------------------------------
  ibte_pkg::ibte_mst_state_type mst, next_mst;
  logic [1:0] next_aps;
  logic addr_phase, active, nack_err, tmo_err, arb_err, col_err;

  assign addr_phase = (mst == ibte_pkg::M_DEV);
  assign active = (mst == ibte_pkg::M_DEV) || (mst == ibte_pkg::M_PER)
    || (mst == ibte_pkg::M_DATA);
  assign arb_err = active && addr_phase && (ev_arb_lost || ev_arb_expired);
  assign col_err = active && !addr_phase && ev_arb_lost;
  assign nack_err = active && ev_nack
    && ((mst != ibte_pkg::M_DATA) || mst_is_write);
  assign tmo_err = active && (ev_byte_timeout || ev_trans_timeout);
  assign mst_abort = arb_err || col_err || nack_err || tmo_err
    || (active && ev_scl_low_timeout);

  always_comb begin
    next_mst = mst;
    next_aps = access_progress_status;
    mst_stop_req = 1'b0;
    case (mst)
      ibte_pkg::M_IDLE: begin
        if (master_transfer_control) begin
          next_mst = ibte_pkg::M_DEV;
          next_aps = ibte_pkg::PH_DEV;
        end
      end
      ibte_pkg::M_STOP: begin
        // Wait for the first point where STOP is legal
        if (stop_legal) begin
          mst_stop_req = 1'b1; // see R12, R13
          next_mst = ibte_pkg::M_IDLE;
        end
      end
      ibte_pkg::M_HUNG: begin
        if (bus_recover) begin
          next_mst = ibte_pkg::M_IDLE; // see R14
        end
      end
      default: begin
        if (active && ev_scl_low_timeout) begin
          next_mst = ibte_pkg::M_HUNG; // see R14
        end else if (arb_err || col_err) begin
          next_mst = ibte_pkg::M_IDLE; // see R10, R11
        end else if (nack_err || tmo_err) begin
          next_mst = ibte_pkg::M_STOP; // see R12, R13
        end else if (mst_done) begin
          next_mst = ibte_pkg::M_IDLE;
          next_aps = ibte_pkg::PH_IDLE;
        end else if (mst_byte_done && mst == ibte_pkg::M_DEV) begin
          next_mst = ibte_pkg::M_PER;
          next_aps = ibte_pkg::PH_PER;
        end else if (mst_byte_done && mst == ibte_pkg::M_PER) begin
          next_mst = ibte_pkg::M_DATA;
          next_aps = ibte_pkg::PH_DATA;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mst <= ibte_pkg::M_IDLE;
      access_progress_status <= ibte_pkg::PH_IDLE;
    end else begin
      mst <= next_mst;
      access_progress_status <= next_aps; // see R12, R13
    end
  end
  assign mst_hung = (mst == ibte_pkg::M_HUNG);

  // ----------------------------------------------------------------
  // Slave access with reserved space
  // ----------------------------------------------------------------
  logic [7:0] ptr, next_ptr, next_rdata;
  logic rsv;

  assign rsv = (ptr >= ibte_pkg::SLAVE_LIMIT);
  assign slv_addr_ack = slv_addr_valid; // see R15, R16
  assign reg_we = slv_wr_req && !rsv; // see R16, R17
  assign reg_addr = ptr;
  assign reg_wdata = slv_wdata;

  always_comb begin
    next_ptr = ptr;
    next_rdata = slv_rdata;
    if (slv_addr_valid) begin
      next_ptr = slv_addr;
    end else if (slv_rd_req || slv_wr_req) begin
      next_ptr = ptr + 8'h01; // see R17
      if (slv_rd_req) begin
        next_rdata = rsv ? ibte_pkg::RESERVED_DATA : reg_rdata; // see R15
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr <= 8'h00;
      slv_rdata <= 8'h00;
    end else begin
      ptr <= next_ptr;
      slv_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags and interrupt
  // ----------------------------------------------------------------
  ibte_pkg::ibte_flags_type ev, next_flags;

  always_comb begin
    ev = '0;
    ev.master_arb_timeout_flag = arb_err; // see R10
    ev.master_collision_flag = col_err; // see R11
    ev.master_not_acked_flag = nack_err; // see R12
    ev.master_timeout_flag = tmo_err || (active && ev_scl_low_timeout);
    ev.master_clock_low_timeout_cause = active && ev_scl_low_timeout;
    ev.master_byte_timeout_cause = active && ev_byte_timeout; // see R13
    ev.master_transaction_timeout_cause = active && ev_trans_timeout;
    ev.slave_access_success_flag = slv_done; // see R15, R16, R17
    // A new event outranks a clear in the same cycle
    next_flags = ibte_pkg::ibte_flags_type'((flag_status & ~flag_clear)
      | ev);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_status <= '0;
    end else begin
      flag_status <= next_flags; // see R18
    end
  end
  assign irq = |(flag_status & flag_enable); // see R18

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_IDLE_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(bst == ibte_pkg::B_RESET) |-> $past(bus_idle, 1)
    && $past(bst) == ibte_pkg::B_DETECT)
    else $error("Reset phase began without idle window"); // see R1
  AST_RESET_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    (bst == ibte_pkg::B_RESET && tick && pcnt == 8'h08)
    |=> bst != ibte_pkg::B_RESET)
    else $error("EEPROM reset phase not nine periods"); // see R2
  AST_ENTRY_1B: assert property (@(posedge clk) disable iff (!rst_n)
    (bst == ibte_pkg::B_LOAD && !page_unlimited && !two_byte_addr)
    |-> budget == 8'h66)
    else $error("One-byte entry budget wrong"); // see R3, R7
  AST_ENTRY_2B: assert property (@(posedge clk) disable iff (!rst_n)
    (bst == ibte_pkg::B_LOAD && !page_unlimited && two_byte_addr)
    |-> budget == 8'h6f)
    else $error("Two-byte entry budget wrong"); // see R6
  AST_ENTRY_PAGE: assert property (@(posedge clk) disable iff (!rst_n)
    (bst == ibte_pkg::B_LOAD && page_unlimited) |-> budget == 8'h48)
    else $error("Page mode entry budget wrong"); // see R8
  AST_STOP_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    (bst == ibte_pkg::B_STOP && tick) |=> bst == ibte_pkg::B_DONE)
    else $error("STOP phase not one period"); // see R4
  AST_PER_RESET: assert property (@(posedge clk)
    $rose(rst_n) |-> per == 16'h00c8)
    else $error("Serial clock period not 10 us at reset"); // see R5
  AST_CHAIN_PER: assert property (@(posedge clk) disable iff (!rst_n)
    (bst == ibte_pkg::B_LOAD && tick && chain_pend && pcnt == budget - 8'h01)
    |=> per == $past(serial_clock_period))
    else $error("Chain did not reload period"); // see R9
  AST_ARB_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
    (mst == ibte_pkg::M_DEV && ev_arb_lost)
    |=> flag_status.master_arb_timeout_flag
    && !$past(ev.master_collision_flag) && mst == ibte_pkg::M_IDLE)
    else $error("Address-phase arbitration loss misreported"); // see R10
  AST_COLLISION: assert property (@(posedge clk) disable iff (!rst_n)
    ((mst == ibte_pkg::M_PER || mst == ibte_pkg::M_DATA) && ev_arb_lost)
    |=> flag_status.master_collision_flag)
    else $error("Late arbitration loss not flagged"); // see R11
  AST_NACK_STOP: assert property (@(posedge clk) disable iff (!rst_n)
    (nack_err && !ev_scl_low_timeout && !ev_arb_lost)
    |=> mst == ibte_pkg::M_STOP
    && flag_status.master_not_acked_flag
    && access_progress_status == $past(access_progress_status))
    else $error("NACK handling wrong"); // see R12
  AST_TMO_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
    (active && ev_byte_timeout) |=> flag_status.master_timeout_flag
    && flag_status.master_byte_timeout_cause)
    else $error("Byte timeout cause missing"); // see R13
  AST_HUNG: assert property (@(posedge clk) disable iff (!rst_n)
    (active && ev_scl_low_timeout) |=> mst_hung
    && flag_status.master_clock_low_timeout_cause)
    else $error("Clock-low timeout did not hang bus"); // see R14
  AST_RSV_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (slv_rd_req && !slv_addr_valid && rsv) |=> slv_rdata == 8'h00)
    else $error("Reserved read returned nonzero"); // see R15, R17
  AST_RSV_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (slv_wr_req && rsv) |-> !reg_we)
    else $error("Reserved write reached registers"); // see R16
  AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    (flag_status.master_not_acked_flag && flag_enable.master_not_acked_flag)
    |-> irq)
    else $error("Enabled flag did not raise interrupt"); // see R18
endmodule : ibte_core

/* test/ibte_bus_partner.sv */
// Far-side bus model: pull-ups and an external master's clock
`timescale 1ns/1ps
module ibte_bus_partner (
  input wire logic scl_pin_out,
  input wire logic scl_pin_oe,
  input wire logic sda_pin_out,
  input wire logic sda_pin_oe,
  input wire logic frame,
  output logic scl_level,
  output logic sda_level
);
  logic ext_scl;
  // ------------------
  // External traffic
  // ------------------
  // Clock runs only inside a frame and rests high between frames
  initial begin
    ext_scl = 1'b1;
    forever begin
      #200 ext_scl = frame ? ~ext_scl : 1'b1;
    end
  end
  // ------------------
  // Open-drain wires
  // ------------------
  // Pull-ups: any party pulling low wins
  assign scl_level = ext_scl & ~(scl_pin_oe & ~scl_pin_out);
  assign sda_level = (frame ? ~ext_scl : 1'b1)
    & ~(sda_pin_oe & ~sda_pin_out);
endmodule : ibte_bus_partner

/* test/testbench.sv */
// Self-checking bench: boot timing, master errors, slave access
`timescale 1ns/1ps
module testbench;
  // ------------------
  // Signals and notes
  // ------------------
  typedef struct packed {
    ibte_pkg::ibte_flags_type flags;
    logic [1:0] phase;
    logic [1:0] stops;
  } ibte_abort_note_type;
  typedef struct packed {
    logic [15:0] rises;
    logic [15:0] hi_last;
  } ibte_boot_note_type;
  localparam int IDLE_EXP = 50000 / 50;
  localparam int HALF_RST = 10000 / 50 / 2;
  logic clk, rst_n, scl_pin_in, sda_pin_in, scl_pin_out, scl_pin_oe;
  logic sda_pin_out, sda_pin_oe, boot_start, two_byte_addr, frame;
  logic page_unlimited, chain_req, boot_busy, boot_done;
  logic [15:0] boot_register_count, chain_register_count;
  logic [15:0] serial_clock_period;
  logic master_transfer_control, mst_is_write, mst_byte_done, mst_done;
  logic stop_legal, bus_recover, mst_abort, mst_stop_req, mst_hung;
  logic [5:0] ev;
  logic [1:0] access_progress_status;
  logic slv_addr_valid, slv_rd_req, slv_wr_req, slv_done;
  logic slv_addr_ack, reg_we, irq;
  logic [7:0] slv_addr, slv_wdata, reg_rdata, slv_rdata, reg_addr;
  logic [7:0] reg_wdata, w, ra;
  ibte_pkg::ibte_flags_type flag_enable, flag_clear, flag_status;
  ibte_abort_note_type abort_q[$];
  ibte_boot_note_type boot_q[$];
  logic [7:0] rd_q[$];
  logic [7:0] flag_q[$];
  logic [15:0] wr_q[$];
  int n_mismatch = 0;
  int checked = 0;
  int cyc, t_ref, idle, n_rise, hi_run, hi_first, hi_last;
  // Register file stand-in: a fixed pattern per address
  assign reg_rdata = reg_addr ^ 8'h5a;
  ibte_core i_ibte_core (
    .clk, .rst_n, .scl_pin_in, .sda_pin_in, .scl_pin_out, .scl_pin_oe,
    .sda_pin_out, .sda_pin_oe, .boot_start, .boot_register_count,
    .two_byte_addr, .page_unlimited, .chain_req, .chain_register_count,
    .serial_clock_period, .boot_busy, .boot_done, .master_transfer_control,
    .mst_is_write, .mst_byte_done, .mst_done, .ev_arb_lost(ev[5]),
    .ev_arb_expired(ev[4]), .ev_nack(ev[3]), .ev_byte_timeout(ev[2]),
    .ev_trans_timeout(ev[1]), .ev_scl_low_timeout(ev[0]), .stop_legal,
    .bus_recover, .mst_abort, .mst_stop_req, .mst_hung,
    .access_progress_status, .slv_addr_valid, .slv_addr, .slv_rd_req,
    .slv_wr_req, .slv_wdata, .slv_done, .reg_rdata, .slv_addr_ack,
    .slv_rdata, .reg_we, .reg_addr, .reg_wdata, .flag_enable, .flag_clear,
    .flag_status, .irq
  );
  ibte_bus_partner i_ibte_bus_partner (
    .scl_pin_out, .scl_pin_oe, .sda_pin_out, .sda_pin_oe, .frame,
    .scl_level(scl_pin_in), .sda_level(sda_pin_in)
  );
  initial begin
    clk = 1'b0;
    forever begin
      #25 clk = ~clk;
    end
  end
  // ------------------
  // Shared tasks
  // ------------------
  task automatic cmp_val(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp_val
  task automatic report_and_stop;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic wait_high(ref logic sig, input int lim);
    int i;
    for (i = 0; i < lim && sig !== 1'b1; i++) begin
      @(posedge clk);
    end
    if (sig !== 1'b1) begin
      cmp_val("wait_done", 16'h1, 16'h0);
      report_and_stop();
    end
  endtask : wait_high
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset
  // Busy cycles of outside traffic hold off the idle detector
  task automatic run_boot(input logic tb, input logic pg,
      input logic [15:0] cnt, input logic [15:0] rises,
      input logic [15:0] last, input int busy, input bit chain);
    int i;
    boot_q.push_back({rises, last});
    {two_byte_addr, page_unlimited, boot_register_count} <= {tb, pg, cnt};
    frame <= (busy > 0);
    n_rise = 0;
    hi_first = 0;
    @(posedge clk);
    boot_start <= 1'b1;
    @(posedge clk);
    boot_start <= 1'b0;
    repeat (busy) @(posedge clk);
    frame <= 1'b0;
    t_ref = cyc;
    for (i = 0; chain && i < 30000 && n_rise < 20; i++) begin
      @(posedge clk);
    end
    chain_req <= chain;
    @(posedge clk);
    chain_req <= 1'b0;
    wait_high(boot_done, 60000);
    repeat (2) @(posedge clk);
  endtask : run_boot
  // Stop code 3 marks an event that must be refused
  task automatic mst_case(input logic [1:0] nb, input logic wr,
      input logic [5:0] e, input logic [7:0] fl, input logic [1:0] st);
    if (st != 2'h3) begin
      abort_q.push_back({fl, nb + 2'h1, st});
    end
    flag_enable <= ibte_pkg::ibte_flags_type'($urandom);
    mst_is_write <= wr;
    @(posedge clk);
    master_transfer_control <= 1'b1;
    @(posedge clk);
    master_transfer_control <= 1'b0;
    repeat (nb) begin
      @(posedge clk);
      mst_byte_done <= 1'b1;
      @(posedge clk);
      mst_byte_done <= 1'b0;
    end
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 6'h00;
    repeat (2) @(posedge clk);
    stop_legal <= 1'b1;
    repeat (3) @(posedge clk);
    stop_legal <= 1'b0;
    repeat (4) @(posedge clk);
    {bus_recover, mst_done, flag_clear} <= {e[0], 1'b1, 8'hff};
    @(posedge clk);
    {bus_recover, mst_done, flag_clear} <= 10'h000;
  endtask : mst_case
  // Kind bits: address, read, write, done
  task automatic slv(input logic [3:0] kind, input logic [7:0] d);
    @(posedge clk);
    {slv_addr_valid, slv_rd_req, slv_wr_req, slv_done} <= kind;
    {slv_addr, slv_wdata} <= {d, d};
    @(posedge clk);
    {slv_addr_valid, slv_rd_req, slv_wr_req, slv_done} <= 4'h0;
  endtask : slv
  // ------------------
  // Output monitor
  // ------------------
  initial begin
    logic prev_oe, prev_done, rd_pend, flg_pend;
    logic [1:0] stops;
    ibte_abort_note_type a;
    ibte_boot_note_type b;
    {prev_oe, prev_done, rd_pend, flg_pend} = 4'h0;
    forever begin
      @(negedge clk);
      cyc++;
      if (scl_pin_oe === 1'b1 && !prev_oe) begin
        n_rise++;
        hi_run = 0;
        idle = (n_rise == 1) ? cyc - t_ref : idle;
      end
      hi_run = hi_run + int'(scl_pin_oe === 1'b1);
      if (scl_pin_oe === 1'b0 && prev_oe) begin
        hi_first = (hi_first == 0) ? hi_run : hi_first;
        hi_last = hi_run;
      end
      if (boot_done === 1'b1 && !prev_done) begin
        b = boot_q.size() ? boot_q.pop_front() : 'x;
        cmp_val("periods", b.rises, 16'(n_rise));
        cmp_val("high_first", 16'(HALF_RST), 16'(hi_first));
        cmp_val("high_last", b.hi_last, 16'(hi_last));
        cmp_val("idle", 16'h1, 16'(idle >= IDLE_EXP
          && idle <= IDLE_EXP + 10));
        cmp_val("busy", 16'h0, 16'(boot_busy));
      end
      if (rd_pend) begin
        cmp_val("read_data", 16'(rd_q.size() ? rd_q.pop_front() : 8'hxx),
          16'(slv_rdata));
      end
      rd_pend = slv_rd_req;
      if (flg_pend) begin
        cmp_val("slave_flags", 16'(flag_q.size() ? flag_q.pop_front()
          : 8'hxx), 16'(flag_status));
      end
      flg_pend = slv_done;
      if (slv_addr_valid === 1'b1) begin
        cmp_val("addr_ack", 16'h1, 16'(slv_addr_ack));
      end
      if (reg_we === 1'b1) begin
        cmp_val("write", wr_q.size() ? wr_q.pop_front() : 'x,
          {reg_addr, reg_wdata});
      end
      if (mst_abort === 1'b1) begin
        a = abort_q.size() ? abort_q.pop_front() : 'x;
        @(negedge clk);
        cmp_val("flags", 16'(a.flags), 16'(flag_status));
        cmp_val("phase", 16'(a.phase), 16'(access_progress_status));
        cmp_val("hung", 16'(a.flags.master_clock_low_timeout_cause),
          16'(mst_hung));
        cmp_val("irq", 16'(|(a.flags & flag_enable)), 16'(irq));
        stops = 2'h0;
        repeat (6) begin
          @(negedge clk);
          stops = stops + 2'(mst_stop_req === 1'b1);
        end
        cmp_val("stops", 16'(a.stops), 16'(stops));
      end
      prev_oe = (scl_pin_oe === 1'b1);
      prev_done = (boot_done === 1'b1);
    end
  end
  // ------------------
  // Main sequence
  // ------------------
  initial begin
    rst_n = 1'b0;
    {boot_start, two_byte_addr, page_unlimited, chain_req, frame} = '0;
    {boot_register_count, chain_register_count} = '0;
    serial_clock_period = 16'h0028;
    {master_transfer_control, mst_is_write, mst_byte_done} = '0;
    {mst_done, stop_legal, bus_recover, ev} = '0;
    {slv_addr_valid, slv_rd_req, slv_wr_req, slv_done} = '0;
    {slv_addr, slv_wdata, flag_enable, flag_clear} = '0;
    void'($urandom(78));
    do_reset();
    cmp_val("reset_flags", 16'h0, 16'(flag_status));
    run_boot(1'b0, 1'b0, 16'h0, 16'(9 + 102 + 102 + 1), 16'h0014, 0,
      1'b1);
    do_reset();
    run_boot(1'b1, 1'b1, 16'h1, 16'(9 + 111 - 72 + 2 * 72 + 1),
      16'(HALF_RST), 300, 1'b0);
    mst_case(2'h0, 1'b0, 6'h20, 8'h80, 2'h0);
    mst_case(2'h0, 1'b1, 6'h10, 8'h80, 2'h0);
    mst_case(2'h1, 1'b1, 6'h20, 8'h40, 2'h0);
    mst_case(2'h2, 1'b0, 6'h20, 8'h40, 2'h0);
    mst_case(2'h0, 1'b0, 6'h08, 8'h20, 2'h1);
    mst_case(2'h1, 1'b0, 6'h08, 8'h20, 2'h1);
    mst_case(2'h2, 1'b1, 6'h08, 8'h20, 2'h1);
    mst_case(2'h2, 1'b0, 6'h08, 8'h00, 2'h3);
    mst_case(2'h1, 1'b1, 6'h04, 8'h14, 2'h1);
    mst_case(2'h2, 1'b0, 6'h02, 8'h12, 2'h1);
    mst_case(2'h1, 1'b0, 6'h01, 8'h18, 2'h0);
    w = 8'($urandom);
    ra = {2'b10, 6'($urandom)};
    rd_q = '{8'h3e ^ 8'h5a, 8'h3f ^ 8'h5a, 8'h00, 8'h00};
    flag_q = '{8'h01, 8'h01, 8'h01};
    wr_q.push_back({8'h3f, w});
    slv(4'h8, 8'h3e);
    repeat (3) slv(4'h4, 8'h00);
    slv(4'h1, 8'h00);
    slv(4'h8, 8'h3f);
    slv(4'h2, w);
    slv(4'h2, ~w);
    slv(4'h1, 8'h00);
    slv(4'h8, ra);
    slv(4'h4, 8'h00);
    slv(4'h2, w);
    slv(4'h1, 8'h00);
    repeat (4) @(posedge clk);
    cmp_val("notes_left", 16'h0, 16'(abort_q.size() + rd_q.size()
      + wr_q.size() + flag_q.size() + boot_q.size()));
    report_and_stop();
  end
endmodule : testbench
